/* File: bench/sar_host.sv */
// Host model: serial master that clocks converter frames
`timescale 1ns/1ps
module sar_host
  import sar_pkg::*;
(
  output logic        conversion_clock_pin,
  output logic        select_n,
  input  wire logic   serial_result_out,
  input  wire logic   serial_result_oe_n,
  output logic [15:0] rx_word,
  output logic        rx_oe_ok
);
  // ------------------------------
  // Frame driver
  // ------------------------------
  // half of a 56 ns period
  localparam int HALF = 28;

  // Clock idles high; power-up select pulse idles the link
  initial
  begin
    conversion_clock_pin = 1'b1;
    select_n             = 1'b0;
    rx_word              = 16'h0000;
    rx_oe_ok             = 1'b1;
    #20;
    select_n             = 1'b1;
  end

  task automatic frame(input int n);
    select_n = 1'b0;
    rx_word  = 16'h0000;
    rx_oe_ok = 1'b1;
    #10;
    repeat (n)
    begin
      conversion_clock_pin = 1'b0;
      #HALF;
      conversion_clock_pin = 1'b1;
      rx_word  = {rx_word[14:0], serial_result_out};
      rx_oe_ok = rx_oe_ok & ~serial_result_oe_n;
      #HALF;
    end
    select_n = 1'b1;
  endtask
endmodule

/* File: bench/tb_sar_readout.sv */
// Self-checking bench of the serial converter readout
`timescale 1ns/1ps
module tb_sar_readout
  import sar_pkg::*;
;
  logic        clk;
  logic        rst_n;
  sar_word_t   sample_in;
  logic        conversion_clock_pin;
  logic        select_n;
  logic        serial_result_out;
  logic        serial_result_oe_n;
  logic        comparator_on;
  logic        track_on;
  sar_word_t   result_code;
  logic        result_valid;
  logic        busy;
  logic [15:0] rx_word;
  logic        rx_oe_ok;
  logic        busy_seen = 1'b0;
  int          n_errors = 0;
  int          checks_done = 0;
  int          n_valid = 0;
  int          cycles = 0;
  sar_word_t   codes [8] = '{12'h800, 12'h801, 12'h000, 12'h001,
                             12'h7fe, 12'h7ff, 12'h555, 12'haaa};

  sar_readout u_sar_readout (
    .clk                (clk),
    .rst_n              (rst_n),
    .sample_in          (sample_in),
    .conversion_clock_pin(conversion_clock_pin),
    .select_n           (select_n),
    .serial_result_out  (serial_result_out),
    .serial_result_oe_n (serial_result_oe_n),
    .comparator_on      (comparator_on),
    .track_on           (track_on),
    .result_code        (result_code),
    .result_valid       (result_valid),
    .busy               (busy)
  );

  sar_host u_sar_host (
    .conversion_clock_pin(conversion_clock_pin),
    .select_n           (select_n),
    .serial_result_out  (serial_result_out),
    .serial_result_oe_n (serial_result_oe_n),
    .rx_word            (rx_word),
    .rx_oe_ok           (rx_oe_ok)
  );

  // ------------------------------
  // Clock, monitors and reporting
  // ------------------------------
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Pulse counting, busy watch and hang limit
  always @(negedge clk)
  begin
    cycles++;
    if (result_valid === 1'b1)
      n_valid++;
    if (busy === 1'b1)
      busy_seen = 1'b1;
    if (cycles == 5000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ------------------------------
  // Scenarios
  // ------------------------------
  // Link back at rest after a frame
  task automatic idle_check();
    repeat (12) @(negedge clk);
    check(16'(serial_result_oe_n), 16'h0001);
    check(16'(comparator_on), 16'h0000);
    check(16'(track_on), 16'h0001);
    check(16'(busy), 16'h0000);
  endtask

  // Full frame; optionally the input moves mid-frame
  task automatic conversion_phase(input sar_word_t v, input bit disturb);
    int nv;
    @(negedge clk);
    sample_in = v;
    repeat (12) @(negedge clk);
    nv = n_valid;
    busy_seen = 1'b0;
    fork
      u_sar_host.frame(16);
      if (disturb)
      begin
        repeat (12) @(negedge clk);
        check(16'(comparator_on), 16'h0001);
        check(16'(track_on), 16'h0000);
        sample_in = ~v;
      end
    join
    idle_check();
    check(rx_word, {3'h0, v, 1'b0});
    check(16'(rx_oe_ok), 16'h0001);
    check(16'(result_code), 16'(v));
    check(16'(n_valid - nv), 16'h0001);
    check(16'(busy_seen), 16'h0001);
  endtask

  // Select raised after ten clocks: no new result
  task automatic short_cycle();
    int        nv;
    sar_word_t keep;
    @(negedge clk);
    sample_in = 12'h123;
    repeat (12) @(negedge clk);
    nv = n_valid;
    keep = result_code;
    u_sar_host.frame(10);
    idle_check();
    check(rx_word, 16'h0009);
    check(16'(n_valid - nv), 16'h0000);
    check(16'(result_code), 16'(keep));
  endtask

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    sample_in = 12'h000;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    u_sar_host.frame(16);
    idle_check();
    foreach (codes[i])
      conversion_phase(codes[i], 1'b0);
    conversion_phase(12'h2c5, 1'b1);
    short_cycle();
    conversion_phase(12'h801, 1'b0);
    wrap_up();
  end
endmodule

/* File: hw/sar_pkg.sv */
// Shared constants and types of the serial converter readout
package sar_pkg;

  // ----------------------------------------------------------------
  // Result format
  // ----------------------------------------------------------------
  localparam int             SAR_BITS      = 12;
  localparam logic [11:0]    SAR_SIGN_MASK = 12'h800; // Two's <-> offset
  localparam logic [11:0]    SAR_ONE       = 12'h001;
  localparam logic [11:0]    SAR_ZERO_WORD = 12'h000;

  // ----------------------------------------------------------------
  // Frame timing, counted in falling edges of the conversion clock
  // ----------------------------------------------------------------
  localparam int             SAR_CNT_W       = 5;
  localparam logic [4:0]     SAR_E_NONE      = 5'h00;
  localparam logic [4:0]     SAR_E_STEP      = 5'h01;
  localparam logic [4:0]     SAR_E_CAPTURE   = 5'h03; // End of auto-zero
  localparam logic [4:0]     SAR_E_FIRST_DEC = 5'h04; // MSB decision
  localparam logic [4:0]     SAR_E_LAST_DEC  = 5'h0f; // LSB decision
  localparam logic [4:0]     SAR_E_FRAME     = 5'h10; // Sixteen edges

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef logic [SAR_BITS-1:0] sar_word_t;

  typedef enum logic [1:0] {
    SAR_TRACK,
    SAR_ZERO,
    SAR_DECIDE,
    SAR_TAIL
  } sar_phase_t;

  // Link-side status carried into the system clock domain
  typedef struct packed {
    logic done;
    logic cmp_on;
  } sar_lstat_t;

endpackage

/* File: hw/sar_readout.sv */
// Serial readout and sequencing of the successive-approximation core
`timescale 1ns/1ps

module sar_readout
  import sar_pkg::*;
(
  input  wire logic      clk,
  input  wire logic      rst_n,
  input  wire sar_word_t sample_in,
  input  wire logic      conversion_clock_pin,
  input  wire logic      select_n,
  output logic           serial_result_out,
  output logic           serial_result_oe_n,
  output logic           comparator_on,
  output logic           track_on,
  output sar_word_t      result_code,
  output logic           result_valid,
  output logic           busy
);

  // ----------------------------------------------------------------
  // Link domain state (falling edge of the conversion clock)
  // ----------------------------------------------------------------
  logic [SAR_CNT_W-1:0] edge_cnt_q;
  logic [SAR_CNT_W-1:0] edge_cnt_d;
  sar_phase_t           phase_q;
  sar_phase_t           phase_d;
  logic                 sd_q;
  logic                 sd_d;
  logic                 oe_n_q;
  logic                 oe_n_d;
  logic                 cmp_on_q;
  logic                 cmp_on_d;
  logic                 track_on_q;
  logic                 track_on_d;
  logic                 frame_done_q;
  logic                 frame_done_d;
  sar_word_t            held_q;
  sar_word_t            held_d;
  sar_word_t            approx_q;
  sar_word_t            approx_d;
  sar_word_t            link_result_q;
  sar_word_t            link_result_d;

  // ----------------------------------------------------------------
  // System domain state
  // ----------------------------------------------------------------
  sar_word_t            sample_q;
  sar_word_t            sample_d;
  sar_word_t            result_code_q;
  sar_word_t            result_code_d;
  logic                 result_valid_q;
  logic                 result_valid_d;
  logic                 done_dly_q;
  logic                 done_dly_d;
  logic                 cs_sync;
  sar_lstat_t           lstat_link;
  sar_lstat_t           lstat_sync;

  // ----------------------------------------------------------------
  // Link sequencing: edge count, SAR decisions, serial output
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [SAR_CNT_W-1:0] e;
    logic [3:0]           b;
    sar_word_t            trial;
    logic                 dec;
    e             = SAR_CNT_W'(edge_cnt_q + SAR_E_STEP);
    b             = 4'h0;
    trial         = SAR_ZERO_WORD;
    dec           = 1'b0;
    edge_cnt_d    = edge_cnt_q;
    held_d        = held_q;
    approx_d      = approx_q;
    link_result_d = link_result_q;
    frame_done_d  = frame_done_q;
    if (edge_cnt_q != SAR_E_FRAME)
      edge_cnt_d = e;
    oe_n_d = 1'b0;
    sd_d = 1'b0;
    cmp_on_d   = (e < SAR_E_LAST_DEC);
    track_on_d = !(e < SAR_E_LAST_DEC);
    if (e == SAR_E_CAPTURE)
    begin
      held_d   = sample_q ^ SAR_SIGN_MASK;
      approx_d = SAR_ZERO_WORD;
    end
    if ((e >= SAR_E_FIRST_DEC) && (e <= SAR_E_LAST_DEC))
    begin
      b        = 4'(SAR_E_LAST_DEC - e);
      trial    = approx_q | (SAR_ONE << b);
      dec      = (held_q >= trial);
      approx_d = dec ? trial : approx_q;
      sd_d     = dec;
      if (e == SAR_E_FIRST_DEC)
        sd_d = !dec;
      if (e == SAR_E_LAST_DEC)
      begin
        link_result_d = approx_d ^ SAR_SIGN_MASK;
        frame_done_d  = 1'b1;
      end
    end
    if (e < SAR_E_FIRST_DEC)
      phase_d = SAR_ZERO;
    else if (e <= SAR_E_LAST_DEC)
      phase_d = SAR_DECIDE;
    else
      phase_d = SAR_TAIL;
  end

  // Control flops; select high forces the idle values
  // release on select
  always_ff @(negedge conversion_clock_pin or posedge select_n)
  begin
    if (select_n)
    begin
      edge_cnt_q   <= SAR_E_NONE;
      phase_q      <= SAR_TRACK;
      sd_q         <= 1'b0;
      oe_n_q       <= 1'b1;
      cmp_on_q     <= 1'b0;
      track_on_q   <= 1'b1;
      frame_done_q <= 1'b0;
    end
    else
    begin
      edge_cnt_q   <= edge_cnt_d;
      phase_q      <= phase_d;
      sd_q         <= sd_d;
      oe_n_q       <= oe_n_d;
      cmp_on_q     <= cmp_on_d;
      track_on_q   <= track_on_d;
      frame_done_q <= frame_done_d;
    end
  end

  // Datapath flops kept across frames
  always_ff @(negedge conversion_clock_pin)
  begin
    held_q        <= held_d;
    approx_q      <= approx_d;
    link_result_q <= link_result_d;
  end

  assign serial_result_out  = sd_q;
  assign serial_result_oe_n = oe_n_q;
  assign comparator_on      = cmp_on_q;
  assign track_on           = track_on_q;

  // ----------------------------------------------------------------
  // Crossings into the system clock domain
  // ----------------------------------------------------------------
  assign lstat_link.done   = frame_done_q;
  assign lstat_link.cmp_on = cmp_on_q;

  sar_sync #(
    .WIDTH (1),
    .INIT  (1'b1)
  ) u_cs_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (select_n),
    .sync_q   (cs_sync)
  );

  sar_sync #(
    .WIDTH ($bits(sar_lstat_t)),
    .INIT  ('0)
  ) u_stat_sync (
    .clk      (clk),
    .rst_n    (rst_n),
    .async_in (lstat_link),
    .sync_q   (lstat_sync)
  );

  // ----------------------------------------------------------------
  // System side: track/hold of the input word, result capture
  // ----------------------------------------------------------------
  always_comb
  begin
    sample_d       = cs_sync ? sample_in : sample_q;
    done_dly_d     = lstat_sync.done;
    result_valid_d = lstat_sync.done && !done_dly_q;
    result_code_d  = result_valid_d ? link_result_q : result_code_q;
    if (!rst_n)
    begin
      sample_d       = SAR_ZERO_WORD;
      done_dly_d     = 1'b0;
      result_valid_d = 1'b0;
      result_code_d  = SAR_ZERO_WORD;
    end
  end

  // System registers
  always_ff @(posedge clk)
  begin
    sample_q       <= sample_d;
    done_dly_q     <= done_dly_d;
    result_valid_q <= result_valid_d;
    result_code_q  <= result_code_d;
  end

  assign result_code  = result_code_q;
  assign result_valid = result_valid_q;
  assign busy         = lstat_sync.cmp_on;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  lead_zero_a: assert property (
    @(negedge conversion_clock_pin) disable iff (select_n)
    (edge_cnt_q != SAR_E_NONE && edge_cnt_q < SAR_E_FIRST_DEC) |-> !sd_q)
    else $error("leading bit not low");

  drive_en_a: assert property (
    @(negedge conversion_clock_pin) disable iff (select_n)
    (edge_cnt_q != SAR_E_NONE) |-> !oe_n_q)
    else $error("output not driven in frame");

  sign_bit_a: assert property (
    @(negedge conversion_clock_pin) disable iff (select_n)
    (edge_cnt_q == SAR_E_FIRST_DEC) |-> (sd_q == !held_q[SAR_BITS-1]))
    else $error("sign bit wrong");

  sar_bit_a: assert property (
    @(negedge conversion_clock_pin) disable iff (select_n)
    (edge_cnt_q > SAR_E_FIRST_DEC && edge_cnt_q <= SAR_E_LAST_DEC) |->
    (sd_q == held_q[4'(SAR_E_LAST_DEC - edge_cnt_q)]))
    else $error("serial bit wrong");

  tail_low_a: assert property (
    @(posedge conversion_clock_pin) disable iff (select_n)
    (phase_q == SAR_TAIL) |->
    (edge_cnt_q == SAR_E_FRAME) && !sd_q && !oe_n_q)
    else $error("tail not held low");

  held_stable_a: assert property (
    @(negedge conversion_clock_pin) disable iff (select_n)
    (edge_cnt_q >= SAR_E_CAPTURE && edge_cnt_q <= SAR_E_LAST_DEC)
    |=> $stable(held_q))
    else $error("held sample moved");

  result_word_a: assert property (
    @(negedge conversion_clock_pin) disable iff (select_n)
    (edge_cnt_q == SAR_E_LAST_DEC) |->
    frame_done_q && (link_result_q == (held_q ^ SAR_SIGN_MASK)))
    else $error("result word wrong");

  power_seq_a: assert property (
    @(negedge conversion_clock_pin) disable iff (select_n)
    (edge_cnt_q != SAR_E_NONE) |-> (track_on_q == !cmp_on_q) &&
    (cmp_on_q == (edge_cnt_q < SAR_E_LAST_DEC)))
    else $error("comparator power wrong");

  idle_off_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    select_n |-> !cmp_on_q && track_on_q && oe_n_q)
    else $error("idle state wrong");

  valid_cap_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(lstat_sync.done) |=> result_valid_q ##1 !result_valid_q)
    else $error("result pulse wrong");

  full_frame_c: cover property (
    @(posedge conversion_clock_pin) edge_cnt_q == SAR_E_FRAME);

  result_c: cover property (
    @(posedge clk) disable iff (!rst_n) result_valid_q);

  short_cycle_c: cover property (
    @(posedge clk) disable iff (!rst_n)
    $fell(lstat_sync.cmp_on) && !lstat_sync.done);

endmodule

/* File: hw/sar_sync.sv */
// Two-stage level synchroniser with synchronous reset value
`timescale 1ns/1ps
module sar_sync
  import sar_pkg::*;
#(
  parameter int               WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT  = '0
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_q
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_d;

  // Next values; first stage feeds only the second
  always_comb
  begin
    meta_d = rst_n ? async_in : INIT;
    sync_d = rst_n ? meta_q : INIT;
  end

  // Stage registers
  always_ff @(posedge clk)
  begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

endmodule
